//--- rtl/rcf_pkg.sv
// Package with register map, field layout, reset values and state type of the reset cause flags.
package rcf_pkg;

    // Printed offsets are register indices; byte address is four times the index.
    localparam logic [7:0] FLAGS_INDEX = 8'h37;
    localparam logic [7:0] MASK_INDEX = 8'h38;
    localparam logic [7:0] FLAGS_ADDR = {FLAGS_INDEX[5:0], 2'b00};
    localparam logic [7:0] MASK_ADDR = {MASK_INDEX[5:0], 2'b00};

    // Bit positions inside the flags register.
    localparam int TICK_BIT = 7;
    localparam int POR_BIT = 6;
    localparam int LVR_BIT = 5;
    localparam int LOCK_CHG_BIT = 4;
    localparam int LOCK_STAT_BIT = 3;
    localparam int ILA_BIT = 2;

    // Implemented sticky flags, and those that survive a system reset.
    localparam logic [7:0] FLAG_MASK = 8'hF4;
    localparam logic [7:0] FLAG_KEEP = 8'h64;
    localparam logic [7:0] POR_FLAGS = 8'h60;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [23:0] READ_PAD = 24'h000000;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [7:0] flags;
        logic [7:0] mask;
        logic [2:0] lockSync;
        logic lockState;
        logic awHeld;
        logic [7:0] awAddr;
        logic wHeld;
        logic [7:0] wData;
        logic wLane;
        logic bValid;
        logic [1:0] bResp;
        logic rValid;
        logic [7:0] rData;
        logic [1:0] rResp;
    } rcf_state_type;

    localparam rcf_state_type STATE_RESET = '{
        flags: ZERO_BYTE,
        mask: MASK_RESET,
        lockSync: 3'h0,
        lockState: 1'b0,
        awHeld: 1'b0,
        awAddr: ZERO_BYTE,
        wHeld: 1'b0,
        wData: ZERO_BYTE,
        wLane: 1'b0,
        bValid: 1'b0,
        bResp: RESP_OKAY,
        rValid: 1'b0,
        rData: ZERO_BYTE,
        rResp: RESP_OKAY
    };

endpackage : rcf_pkg

//--- rtl/rcf_flags.sv
// Reset cause and tick flag register with AXI4-Lite access and interrupt output.
module rcf_flags (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic powerOnReset,
    input wire logic tickEvent,
    input wire logic lowVoltageReset,
    input wire logic illegalAddressReset,
    input wire logic pllLock,
    output logic irq,
    output logic lockStatus,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    rcf_pkg::rcf_state_type r;
    rcf_pkg::rcf_state_type next_r;

    logic wrFire;
    logic wrFlags;
    logic wrMask;
    logic [7:0] clrVec;
    logic [7:0] setVec;
    logic lockChange;
    logic [7:0] flagsView;

    // A write completes once both address and data are held and no response is pending.
    assign wrFire = r.awHeld & r.wHeld & ~r.bValid;
    assign wrFlags = wrFire & r.wLane & (r.awAddr == rcf_pkg::FLAGS_ADDR);
    assign wrMask = wrFire & r.wLane & (r.awAddr == rcf_pkg::MASK_ADDR);
    assign clrVec = wrFlags ? (r.wData & rcf_pkg::FLAG_MASK) : rcf_pkg::ZERO_BYTE;

    // The lock level is taken as settled once the last two stages agree.
    assign lockChange = (r.lockSync[1] == r.lockSync[2]) & (r.lockSync[2] != r.lockState);

    always_comb begin
        setVec = rcf_pkg::ZERO_BYTE;
        setVec[rcf_pkg::TICK_BIT] = tickEvent;
        setVec[rcf_pkg::LVR_BIT] = lowVoltageReset;
        setVec[rcf_pkg::LOCK_CHG_BIT] = lockChange;
        setVec[rcf_pkg::ILA_BIT] = illegalAddressReset;
    end

    always_comb begin
        flagsView = r.flags;
        flagsView[rcf_pkg::LOCK_STAT_BIT] = r.lockState;
    end

    assign s_axi_awready = ~r.awHeld & ~r.bValid;
    assign s_axi_wready = ~r.wHeld & ~r.bValid;
    assign s_axi_bvalid = r.bValid;
    assign s_axi_bresp = r.bResp;
    assign s_axi_arready = ~r.rValid;
    assign s_axi_rvalid = r.rValid;
    assign s_axi_rresp = r.rResp;
    assign s_axi_rdata = {rcf_pkg::READ_PAD, r.rData};
    assign lockStatus = r.lockState;

    // Only flags with their enable bit set can request; reset causes are maskable too.
    assign irq = |(r.flags & r.mask);

    always_comb begin
        next_r = r;
        next_r.lockSync = {r.lockSync[1:0], pllLock};
        if (lockChange) begin
            next_r.lockState = r.lockSync[2];
        end
        // Set is applied after the clear so that a same-cycle event survives.
        next_r.flags = ((r.flags & ~clrVec) | setVec) & rcf_pkg::FLAG_MASK;
        if (wrMask) begin
            next_r.mask = r.wData & rcf_pkg::FLAG_MASK;
        end
        if (s_axi_awvalid & s_axi_awready) begin
            next_r.awHeld = 1'b1;
            next_r.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid & s_axi_wready) begin
            next_r.wHeld = 1'b1;
            next_r.wData = s_axi_wdata[7:0];
            next_r.wLane = s_axi_wstrb[0];
        end
        if (wrFire) begin
            next_r.awHeld = 1'b0;
            next_r.wHeld = 1'b0;
            next_r.bValid = 1'b1;
            if ((r.awAddr == rcf_pkg::FLAGS_ADDR) | (r.awAddr == rcf_pkg::MASK_ADDR)) begin
                next_r.bResp = rcf_pkg::RESP_OKAY;
            end else begin
                next_r.bResp = rcf_pkg::RESP_SLVERR;
            end
        end
        if (r.bValid & s_axi_bready) begin
            next_r.bValid = 1'b0;
        end
        if (s_axi_arvalid & s_axi_arready) begin
            next_r.rValid = 1'b1;
            if (s_axi_araddr == rcf_pkg::FLAGS_ADDR) begin
                next_r.rData = flagsView;
                next_r.rResp = rcf_pkg::RESP_OKAY;
            end else if (s_axi_araddr == rcf_pkg::MASK_ADDR) begin
                next_r.rData = r.mask;
                next_r.rResp = rcf_pkg::RESP_OKAY;
            end else begin
                next_r.rData = rcf_pkg::ZERO_BYTE;
                next_r.rResp = rcf_pkg::RESP_SLVERR;
            end
        end
        if (r.rValid & s_axi_rready) begin
            next_r.rValid = 1'b0;
        end
        // A system reset clears everything except the reset cause flags.
        if (reset) begin
            next_r = rcf_pkg::STATE_RESET;
            next_r.flags = r.flags & rcf_pkg::FLAG_KEEP;
        end
        // Power-on is the stronger reset and alone decides the reset cause flags.
        if (powerOnReset) begin
            next_r = rcf_pkg::STATE_RESET;
            next_r.flags = rcf_pkg::POR_FLAGS;
        end
    end

    always_ff @(posedge sys_clk) begin
        r <= next_r;
    end

    // Checks of the flag behaviour; power-on reset counts as a reset as well.
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset | powerOnReset);

    logic quiet;
    assign quiet = ~reset & ~powerOnReset;

    tick_set_a: assert property (tickEvent |=> r.flags[rcf_pkg::TICK_BIT] || $past(reset)
        || $past(powerOnReset))
        else $error("tick event did not set the tick flag");

    tick_hold_a: assert property ((r.flags[rcf_pkg::TICK_BIT] && !tickEvent
        && !clrVec[rcf_pkg::TICK_BIT]) ##1 quiet |-> r.flags[rcf_pkg::TICK_BIT])
        else $error("tick flag lost without a write of one");

    tick_clear_a: assert property ((wrFlags && r.wData[rcf_pkg::TICK_BIT]
        && !tickEvent) ##1 quiet |-> !r.flags[rcf_pkg::TICK_BIT])
        else $error("write of one did not clear the tick flag");

    irq_gate_a: assert property (irq == (|({r.flags[rcf_pkg::TICK_BIT],
        r.flags[rcf_pkg::LOCK_CHG_BIT]} & {r.mask[rcf_pkg::TICK_BIT], r.mask[rcf_pkg::LOCK_CHG_BIT]})
        || |(r.flags & r.mask & rcf_pkg::FLAG_KEEP)))
        else $error("interrupt does not follow flags and enables");

    // A disabled tick source must never be the only reason for a request.
    tick_masked_a: assert property ((r.mask[rcf_pkg::TICK_BIT] == 1'b0)
        && ((r.flags & r.mask) == rcf_pkg::ZERO_BYTE) |-> !irq)
        else $error("interrupt raised with no enabled flag set");

    lock_irq_a: assert property (r.flags[rcf_pkg::LOCK_CHG_BIT] && r.mask[rcf_pkg::LOCK_CHG_BIT] |-> irq)
        else $error("enabled lock-change flag gives no interrupt");

    ila_clear_a: assert property ((wrFlags && r.wData[rcf_pkg::ILA_BIT]
        && !illegalAddressReset) ##1 quiet |-> !r.flags[rcf_pkg::ILA_BIT])
        else $error("write of one did not clear the illegal-address flag");

    tick_irq_a: assert property (r.flags[rcf_pkg::TICK_BIT] && r.mask[rcf_pkg::TICK_BIT] |-> irq)
        else $error("enabled tick flag gives no interrupt");

    por_values_a: assert property (disable iff (1'b0) $past(powerOnReset) |->
        r.flags[rcf_pkg::POR_BIT] && r.flags[rcf_pkg::LVR_BIT] && !r.flags[rcf_pkg::ILA_BIT])
        else $error("power-on reset left wrong reset cause flags");

    sys_keep_a: assert property (disable iff (powerOnReset)
        reset |=> (r.flags & rcf_pkg::FLAG_KEEP) == ($past(r.flags) & rcf_pkg::FLAG_KEEP))
        else $error("system reset changed a reset cause flag");

    por_write0_a: assert property ((wrFlags && !r.wData[rcf_pkg::POR_BIT]) ##1 quiet
        |-> r.flags[rcf_pkg::POR_BIT] == $past(r.flags[rcf_pkg::POR_BIT]))
        else $error("write of zero changed the power-on flag");

    lvr_set_a: assert property (lowVoltageReset ##1 quiet |-> r.flags[rcf_pkg::LVR_BIT])
        else $error("low-voltage reset did not set its flag");

    ila_set_a: assert property (illegalAddressReset ##1 quiet |-> r.flags[rcf_pkg::ILA_BIT])
        else $error("illegal-address reset did not set bit two");

    lock_chg_a: assert property (lockChange ##1 quiet |-> r.flags[rcf_pkg::LOCK_CHG_BIT]
        && r.lockState != $past(r.lockState))
        else $error("lock change did not set the lock-change flag");

    lock_delay_a: assert property (($stable(pllLock) [*4]) ##1 quiet |-> r.lockState == $past(pllLock, 4))
        else $error("lock status not settled four cycles after a steady level");

    set_wins_a: assert property ((tickEvent && clrVec[rcf_pkg::TICK_BIT]) ##1 quiet
        |-> r.flags[rcf_pkg::TICK_BIT])
        else $error("clear won over a same-cycle set");

    bresp_a: assert property (wrFire |=> s_axi_bvalid)
        else $error("write response missing one cycle after completion");

    rvalid_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data missing one cycle after address");

    tick_irq_c: cover property (tickEvent ##1 irq);
    lock_chg_c: cover property (lockChange ##1 r.flags[rcf_pkg::LOCK_CHG_BIT]);
    clear_c: cover property (wrFlags && r.wData[rcf_pkg::TICK_BIT] ##1 !r.flags[rcf_pkg::TICK_BIT]);
    race_c: cover property (tickEvent && clrVec[rcf_pkg::TICK_BIT]);

endmodule : rcf_flags

//--- dv/rcf_flags_tb.sv
// Self-checking bench for the reset cause and event flag register.
module rcf_flags_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, reset, powerOnReset, tickEvent, lowVoltageReset, illegalAddressReset, pllLock, irq, lockStatus;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, watch;
    logic [7:0] s_axi_awaddr, s_axi_araddr, expF, expM;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [2:0] e;
    int errors, total_checks;

    rcf_flags DUT (.sys_clk, .reset, .powerOnReset, .tickEvent, .lowVoltageReset, .illegalAddressReset, .pllLock,
        .irq, .lockStatus, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // Handshakes are judged at the rising edge; each channel is released right after the edge that takes it.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        logic [4:0] pend;
        pend = {wr, wr, wr, !wr, !wr};
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= {24'h000000, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= pend;
        while (pend != 5'h00) begin
            @(posedge sys_clk);
            if (pend[4] && s_axi_awready) pend[4] = 1'b0;
            if (pend[3] && s_axi_wready) pend[3] = 1'b0;
            if (pend[2] && s_axi_bvalid) begin
                resp = s_axi_bresp;
                pend[2] = 1'b0;
            end
            if (pend[1] && s_axi_arready) pend[1] = 1'b0;
            if (pend[0] && s_axi_rvalid) begin
                resp = s_axi_rresp;
                rd = s_axi_rdata;
                pend[0] = 1'b0;
            end
            {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= pend;
        end
    endtask : bus

    task automatic rdChk(input string name, input logic [7:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        chk(name, rd, {24'h000000, exp});
    endtask : rdChk

    task automatic wrF(input logic [7:0] d);
        bus(1'b1, rcf_pkg::FLAGS_ADDR, d);
        expF = expF & ~(d & 8'hF4);
    endtask : wrF

    task automatic wrM(input logic [7:0] d);
        bus(1'b1, rcf_pkg::MASK_ADDR, d);
        expM = d & 8'hF4;
    endtask : wrM

    task automatic irqChk(input logic exp);
        @(negedge sys_clk);
        chk("irq", {31'h0, irq}, {31'h0, exp});
    endtask : irqChk

    task automatic ev(input logic [2:0] v);
        @(posedge sys_clk);
        {tickEvent, lowVoltageReset, illegalAddressReset} <= v;
        @(posedge sys_clk);
        {tickEvent, lowVoltageReset, illegalAddressReset} <= 3'h0;
        expF = expF | {v[2], 1'b0, v[1], 2'h0, v[0], 2'h0};
    endtask : ev

    task automatic rst(input logic por);
        @(posedge sys_clk);
        {reset, powerOnReset} <= {1'b1, por};
        repeat (10) @(posedge sys_clk);
        {reset, powerOnReset} <= 2'h0;
        expF = por ? 8'h60 : (expF & 8'h64);
        expM = 8'h00;
    endtask : rst

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test

    // A clear that loses to a same-cycle set must never let the interrupt drop.
    always @(negedge sys_clk) if (watch) chk("irq during clash", {31'h0, irq}, 32'h1);

    initial begin
        {reset, powerOnReset, tickEvent, lowVoltageReset, illegalAddressReset, pllLock, watch} = 7'h60;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {16'h0000, 32'h00000000, 4'hF};
        {errors, total_checks, expF} = 0;
        void'($urandom(67));
        rst(1'b1);
        rdChk("flags after power-on", rcf_pkg::FLAGS_ADDR, 8'h60);
        rdChk("mask after reset", rcf_pkg::MASK_ADDR, 8'h00);
        wrF(8'h00);
        rdChk("write zero", rcf_pkg::FLAGS_ADDR, expF);
        wrF(8'h40);
        rdChk("clear power-on", rcf_pkg::FLAGS_ADDR, expF);
        wrF(8'h20);
        rdChk("clear low-voltage", rcf_pkg::FLAGS_ADDR, expF);
        ev(3'h3);
        ev(3'h4);
        rdChk("events", rcf_pkg::FLAGS_ADDR, expF);
        rst(1'b0);
        rdChk("after system reset", rcf_pkg::FLAGS_ADDR, expF);
        rst(1'b1);
        rdChk("after power-on again", rcf_pkg::FLAGS_ADDR, expF);
        $display("test reset causes done");
        ev(3'h4);
        irqChk(1'b0);
        wrM(8'h80);
        irqChk(1'b1);
        @(posedge sys_clk);
        {tickEvent, watch} <= 2'h3;
        bus(1'b1, rcf_pkg::FLAGS_ADDR, 8'h80);
        @(posedge sys_clk);
        {tickEvent, watch} <= 2'h0;
        rdChk("set beats clear", rcf_pkg::FLAGS_ADDR, expF);
        wrF(8'h80);
        irqChk(1'b0);
        $display("test tick interrupt done");
        @(posedge sys_clk);
        pllLock <= 1'b1;
        repeat (6) @(posedge sys_clk);
        expF = expF | 8'h18;
        rdChk("lock change", rcf_pkg::FLAGS_ADDR, expF);
        wrM(8'h10);
        irqChk(1'b1);
        wrF(8'h10);
        irqChk(1'b0);
        @(posedge sys_clk);
        pllLock <= 1'b0;
        repeat (6) @(posedge sys_clk);
        expF = (expF & 8'hF7) | 8'h10;
        rdChk("lock lost", rcf_pkg::FLAGS_ADDR, expF);
        chk("lock status", {31'h0, lockStatus}, 32'h0);
        wrF(8'hFF);
        bus(1'b0, 8'h00, 8'h00);
        chk("unmapped read data", rd, 32'h0);
        chk("unmapped read resp", {30'h0, resp}, {30'h0, rcf_pkg::RESP_SLVERR});
        bus(1'b1, 8'h04, 8'hFF);
        chk("unmapped write", {30'h0, resp}, {30'h0, rcf_pkg::RESP_SLVERR});
        $display("test lock and unmapped done");
        for (int i = 0; i < 24; i++) begin
            e = 3'($urandom);
            ev(e);
            wrM(8'($urandom));
            wrF(8'($urandom));
            rdChk("random flags", rcf_pkg::FLAGS_ADDR, expF);
            rdChk("random mask", rcf_pkg::MASK_ADDR, expM);
            irqChk(|(expF & expM));
        end
        $display("test random done");
        end_of_test();
    end

    // About 550 cycles are needed; the limit of 50000 cycles leaves wide margin.
    initial begin
        #200000;
        errors++;
        end_of_test();
    end
endmodule : rcf_flags_tb
